/* File: core/nvm_ctrl.sv */
// design: flash access, boot map, lock and nvm configuration logic
`timescale 1ns/1ps
// Notes on behaviour
// - sram seen only at its base until remap, then also at zero
// - rom always decoded at its fixed base
// - flash always decoded at its fixed base
// - config bit 2 set aliases flash at zero, else rom, until remap
// - config bits change through set and clear config commands and the qualified erase pin
// - qualified erase pin clears the boot select bit
// - 256 byte pages as 32-bit words with a page write buffer
// - flash put into standby whenever no access is in progress
// - command port starts commands and reports done and error status
// - two-entry 32-bit prefetch buffer serves sequential halfword fetches
// - each bank runs its own sequencer; reads continue in idle bank
// - lock region is 64 pages; 16 lock bits per bank
// - program or program with erase in locked region aborted and interrupt raised; full erase not checked
// - set lock and clear lock commands change the region lock bit
// - qualified erase pin clears every lock bit
// - security bit refuses debug and fast programming accesses to flash
// - security set by command only, cleared by erase pin with full erase
// - config bit 0 enables brownout detector, cleared by erase pin
// - config bit 1 enables brownout reset, cleared by erase pin
// - program with erase 6 ms, program alone 3 ms, full erase 15 ms
// - erase pin high under 100 ms ignored, over 220 ms acts
module nvm_ctrl
   import nvm_ctrl_pkg::*;
#(
   parameter longint PROG_ERASE_CYCLES = PROG_ERASE_CYC,
   parameter longint PROG_ONLY_CYCLES = PROG_ONLY_CYC,
   parameter longint FULL_ERASE_CYCLES = FULL_ERASE_CYC,
   parameter longint ERASE_VALID_CYCLES = ERASE_VALID_CYC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic erase_pin_i,
   input wire logic remap_i,
   input wire bus_req_t bus_req_i,
   input wire logic [31:0] wdata_i,
   input wire cmd_req_t cmd_i,
   input wire logic [1:0] wait_states_i,
   output mem_sel_t sel_o,
   output logic refused_o,
   output logic prefetch_hit_o,
   output logic [31:0] prefetch_data_o,
   output logic flash_standby_o,
   output logic [NUM_BANKS-1:0] bank_busy_o,
   output cmd_status_t status_o,
   output logic irq_o,
   output logic [CFG_BITS-1:0] config_bits_o,
   output logic bod_en_o,
   output logic bod_rst_en_o,
   output logic security_o,
   output logic [2*LOCK_BITS-1:0] lock_bits_o,
   output logic remapped_o,
   output logic [5:0] wbuf_index_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic in_area(input logic [31:0] a, input logic [31:0] base);
      in_area = (a[31:AREA_BITS] == base[31:AREA_BITS]);
   endfunction

   function automatic logic [TIMER_W-1:0] cyc(input longint n);
      cyc = (n < 1) ? TIMER_W'(1) : TIMER_W'(n);
   endfunction

   // ----------------------------------------
   // erase pin synchroniser and qualifier
   // ----------------------------------------
   logic [2:0] pin_sync_q;
   logic pin_level_q;
   logic [TIMER_W-1:0] pin_cnt_q;
   logic erase_fire_q;
   logic erase_armed_q;

   // three stages; level changes once the last two agree
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_sync_q <= 3'h0;
         pin_level_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], erase_pin_i};
         if (pin_sync_q[2] == pin_sync_q[1]) begin
            pin_level_q <= pin_sync_q[2];
         end
      end
   end

   // high time counted; short pulses never reach the count
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_cnt_q <= '0;
         erase_fire_q <= 1'b0;
         erase_armed_q <= 1'b0;
      end else begin
         erase_fire_q <= 1'b0;
         if (!pin_level_q) begin
            pin_cnt_q <= '0;
            erase_armed_q <= 1'b0;
         end else if (!erase_armed_q) begin
            if (pin_cnt_q >= cyc(ERASE_VALID_CYCLES) - TIMER_W'(1)) begin
               erase_fire_q <= 1'b1;
               erase_armed_q <= 1'b1;
            end else begin
               pin_cnt_q <= pin_cnt_q + TIMER_W'(1);
            end
         end
      end
   end

   // ----------------------------------------
   // command acceptance
   // ----------------------------------------
   logic [NUM_BANKS-1:0] busy_q;
   logic [TIMER_W-1:0] timer_q [NUM_BANKS];
   logic cmd_ok;
   logic cmd_locked;
   logic cmd_busy;
   logic is_array_cmd;
   logic [3:0] region;

   always_comb begin
      region = cmd_i.page[PAGE_BITS-1:PAGE_BITS-4];   // 64 pages per region
      is_array_cmd = (cmd_i.code == CMD_PROG) || (cmd_i.code == CMD_PROG_ERASE)
                     || (cmd_i.code == CMD_FULL_ERASE);
      cmd_busy = busy_q[cmd_i.bank];
      cmd_locked = ((cmd_i.code == CMD_PROG) || (cmd_i.code == CMD_PROG_ERASE))
                   && lock_bits_o[{cmd_i.bank, region}];
      cmd_ok = cmd_i.valid && (cmd_i.key == CMD_KEY)
               && (cmd_i.code != CMD_NONE) && !cmd_busy && !cmd_locked;
   end

   // ----------------------------------------
   // per-bank sequencers
   // ----------------------------------------
   // each bank times its own command; reads to the other bank still decoded, but the prefetch is flushed while either bank is busy
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         busy_q <= '0;
         for (int b = 0; b < NUM_BANKS; b++) begin
            timer_q[b] <= '0;
         end
      end else begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (busy_q[b]) begin
               if (timer_q[b] == TIMER_W'(1)) begin
                  busy_q[b] <= 1'b0;
               end
               timer_q[b] <= timer_q[b] - TIMER_W'(1);
            end
         end
         if (cmd_ok && is_array_cmd) begin
            busy_q[cmd_i.bank] <= 1'b1;
            unique case (cmd_i.code)
               CMD_PROG: timer_q[cmd_i.bank] <= cyc(PROG_ONLY_CYCLES);
               CMD_PROG_ERASE: timer_q[cmd_i.bank] <= cyc(PROG_ERASE_CYCLES);
               default: timer_q[cmd_i.bank] <= cyc(FULL_ERASE_CYCLES);
            endcase
         end
      end
   end

   // done, error and interrupt outputs
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         status_o <= '0;
         irq_o <= 1'b0;
         bank_busy_o <= '0;
      end else begin
         bank_busy_o <= busy_q;
         status_o.done <= (cmd_ok && !is_array_cmd)
                          || |(busy_q & {timer_q[1] == TIMER_W'(1), timer_q[0] == TIMER_W'(1)});
         status_o.lock_err <= cmd_i.valid && cmd_locked;
         status_o.cmd_err <= cmd_i.valid && ((cmd_i.key != CMD_KEY) || cmd_busy);
         irq_o <= cmd_i.valid && (cmd_locked || (cmd_i.key != CMD_KEY) || cmd_busy);
      end
   end

   // ----------------------------------------
   // non-volatile bits
   // ----------------------------------------
   logic [CFG_BITS-1:0] cfg_q;
   logic [2*LOCK_BITS-1:0] lock_q;
   logic secure_q;
   logic erase_seen_q;

   // erase pin clears after the command write so it always wins
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= '0;
         lock_q <= '0;
      end else begin
         if (cmd_ok && cmd_i.code == cmd_set_config_bit) begin
            cfg_q[cmd_i.bit_sel] <= 1'b1;
         end
         if (cmd_ok && cmd_i.code == cmd_clear_config_bit) begin
            cfg_q[cmd_i.bit_sel] <= 1'b0;
         end
         if (cmd_ok && cmd_i.code == CMD_SET_LOCK) begin
            lock_q[{cmd_i.bank, region}] <= 1'b1;
         end
         if (cmd_ok && cmd_i.code == CMD_CLEAR_LOCK) begin
            lock_q[{cmd_i.bank, region}] <= 1'b0;
         end
         if (erase_fire_q) begin
            cfg_q <= '0;
            lock_q <= '0;
         end
      end
   end

   // security: set by command, cleared by pin then full erase
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         secure_q <= 1'b0;
         erase_seen_q <= 1'b0;
      end else begin
         if (erase_fire_q) begin
            erase_seen_q <= 1'b1;
         end
         if (cmd_ok && cmd_i.code == CMD_SET_SECURITY) begin
            secure_q <= 1'b1;
         end else if ((erase_seen_q || erase_fire_q) && cmd_ok && cmd_i.code == CMD_FULL_ERASE) begin
            secure_q <= 1'b0;
            erase_seen_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // address decode and boot map
   // ----------------------------------------
   logic remap_q;
   mem_sel_t sel;
   logic deny;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         remap_q <= 1'b0;
      end else if (remap_i) begin
         remap_q <= 1'b1;
      end
   end

   always_comb begin
      deny = secure_q && (bus_req_i.debug_src || bus_req_i.fast_prog_src);
      sel = SEL_NONE;
      if (in_area(bus_req_i.addr, FLASH_BASE)) begin
         sel = SEL_FLASH;
      end else if (in_area(bus_req_i.addr, SRAM_BASE)) begin
         sel = SEL_SRAM;
      end else if (in_area(bus_req_i.addr, ROM_BASE)) begin
         sel = SEL_ROM;
      end else if (in_area(bus_req_i.addr, ZERO_BASE)) begin
         if (remap_q) begin
            sel = SEL_SRAM;
         end else if (cfg_q[CFG_BOOT_FLASH]) begin
            sel = SEL_FLASH;
         end else begin
            sel = SEL_ROM;
         end
      end
      if (deny && sel == SEL_FLASH) begin
         sel = SEL_DENY;
      end
      if (!bus_req_i.valid) begin
         sel = SEL_NONE;
      end
   end

   // ----------------------------------------
   // write buffer and prefetch
   // ----------------------------------------
   logic [31:0] wbuf_q [PAGE_WORDS];
   logic [31:0] pf_data_q [2];
   logic [31:0] pf_addr_q [2];
   logic [1:0] pf_valid_q;
   logic flash_wr;
   logic flash_rd;
   logic pf_hit;
   logic pf_slot;

   assign flash_wr = (sel == SEL_FLASH) && bus_req_i.write;
   assign flash_rd = (sel == SEL_FLASH) && !bus_req_i.write;

   // page buffer filled word by word through the 32-bit port
   always_ff @(posedge ref_clk_i) begin
      if (flash_wr) begin
         wbuf_q[bus_req_i.addr[7:2]] <= wdata_i;
      end
   end

   always_comb begin
      pf_hit = 1'b0;
      pf_slot = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (pf_valid_q[i] && pf_addr_q[i][31:2] == bus_req_i.addr[31:2]) begin
            pf_hit = 1'b1;
            pf_slot = 1'(i);
         end
      end
   end

   // two words held; next word fetched ahead on every flash read while no bank is busy
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pf_valid_q <= 2'h0;
         pf_addr_q[0] <= '0;
         pf_addr_q[1] <= '0;
      end else if (flash_wr || |busy_q) begin
         pf_valid_q <= 2'h0;
      end else if (flash_rd) begin
         pf_addr_q[0] <= {bus_req_i.addr[31:2], 2'h0};
         pf_addr_q[1] <= {bus_req_i.addr[31:2], 2'h0} + 32'h4;
         pf_valid_q <= 2'h3;
      end
   end

   // array data stands in for flash contents from the page buffer
   always_ff @(posedge ref_clk_i) begin
      if (flash_rd) begin
         pf_data_q[0] <= wbuf_q[bus_req_i.addr[7:2]];
         pf_data_q[1] <= wbuf_q[6'(bus_req_i.addr[7:2] + 6'h1)];
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sel_o <= SEL_NONE;
         refused_o <= 1'b0;
         prefetch_hit_o <= 1'b0;
         prefetch_data_o <= '0;
         flash_standby_o <= 1'b1;
         config_bits_o <= '0;
         bod_en_o <= 1'b0;
         bod_rst_en_o <= 1'b0;
         security_o <= 1'b0;
         lock_bits_o <= '0;
         remapped_o <= 1'b0;
         wbuf_index_o <= '0;
      end else begin
         sel_o <= sel;
         refused_o <= (sel == SEL_DENY);
         prefetch_hit_o <= flash_rd && pf_hit && (wait_states_i != 2'h0);
         prefetch_data_o <= pf_data_q[pf_slot];
         flash_standby_o <= !(flash_rd || flash_wr) && !(|busy_q);
         config_bits_o <= cfg_q;
         bod_en_o <= cfg_q[CFG_BOD_EN];
         bod_rst_en_o <= cfg_q[CFG_BOD_RST];
         security_o <= secure_q;
         lock_bits_o <= lock_q;
         remapped_o <= remap_q;
         if (flash_wr) begin
            wbuf_index_o <= bus_req_i.addr[7:2];
         end
      end
   end

endmodule

/* File: shared/nvm_ctrl_pkg.sv */
// package: constants, commands and carriers for the flash nvm controller
package nvm_ctrl_pkg;

   // ----------------------------------------
   // memory map
   // ----------------------------------------
   localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
   localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
   localparam logic [31:0] ROM_BASE = 32'h0030_0000;
   localparam logic [31:0] ZERO_BASE = 32'h0000_0000;
   localparam int AREA_BITS = 20;          // each area spans 1 Mbyte

   // ----------------------------------------
   // flash geometry
   // ----------------------------------------
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_WORDS = 64;         // 256 bytes as 32-bit words
   localparam int PAGES_PER_REGION = 64;
   localparam int LOCK_BITS = 16;
   localparam int PAGE_BITS = 10;          // 1024 pages per bank
   localparam int NUM_BANKS = 2;
   localparam int CFG_BITS = 3;
   localparam int CFG_BOD_EN = 0;
   localparam int CFG_BOD_RST = 1;
   localparam int CFG_BOOT_FLASH = 2;
   localparam logic [7:0] CMD_KEY = 8'h5a;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam longint CLK_HZ = 40_000_000;
   localparam longint PROG_ERASE_MS = 6;
   localparam longint PROG_ONLY_MS = 3;
   localparam longint FULL_ERASE_MS = 15;
   localparam longint ERASE_IGNORE_MS = 100;
   localparam longint ERASE_VALID_MS = 220;
   localparam longint PROG_ERASE_CYC = PROG_ERASE_MS * CLK_HZ / 1000;
   localparam longint PROG_ONLY_CYC = PROG_ONLY_MS * CLK_HZ / 1000;
   localparam longint FULL_ERASE_CYC = FULL_ERASE_MS * CLK_HZ / 1000;
   localparam longint ERASE_VALID_CYC = ERASE_VALID_MS * CLK_HZ / 1000;
   localparam int TIMER_W = 24;

   // ----------------------------------------
   // commands and carriers
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE, CMD_PROG, CMD_PROG_ERASE, CMD_FULL_ERASE, CMD_SET_LOCK,
      CMD_CLEAR_LOCK, cmd_set_config_bit, cmd_clear_config_bit, CMD_SET_SECURITY
   } cmd_code_t;

   typedef struct packed {
      logic valid;
      logic [7:0] key;
      cmd_code_t code;
      logic bank;
      logic [PAGE_BITS-1:0] page;
      logic [1:0] bit_sel;
   } cmd_req_t;

   typedef struct packed {
      logic done;
      logic lock_err;
      logic cmd_err;
   } cmd_status_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic debug_src;          // in_circuit_debug_port
      logic fast_prog_src;      // fast_programming_port
      logic [31:0] addr;
   } bus_req_t;

   typedef enum logic [2:0] {
      SEL_NONE, SEL_FLASH, SEL_SRAM, SEL_ROM, SEL_DENY
   } mem_sel_t;

endpackage

/* File: tb/bus_master_model.sv */
// partner: core-side bus master issuing one-cycle requests
`timescale 1ns/1ps
module bus_master_model
   import nvm_ctrl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic go_i,
   input wire logic write_i,
   input wire logic debug_i,
   input wire logic fast_prog_i,
   input wire logic [31:0] addr_i,
   output bus_req_t req_o
);
   // --------------------------------
   // request driver
   // --------------------------------
   bus_req_t next_q;
   // taken at the rising edge so falling-edge bench writes never race it
   always @(posedge ref_clk_i) begin
      next_q <= '{valid: go_i, write: write_i, debug_src: debug_i, fast_prog_src: fast_prog_i,
                  addr: go_i ? addr_i : ~addr_i};
   end
   // launch after the falling edge; idle address is the inverse of the last one
   always @(negedge ref_clk_i) begin
      req_o <= next_q;
   end
endmodule

/* File: tb/nvm_ctrl_chk.sv */
// checker: port assertions for the flash nvm controller
`timescale 1ns/1ps
module nvm_ctrl_chk
   import nvm_ctrl_pkg::*;
#(
   parameter longint ERASE_VALID_CYCLES = ERASE_VALID_CYC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic erase_pin_i,
   input wire bus_req_t bus_req_i,
   input wire cmd_req_t cmd_i,
   input wire mem_sel_t sel_o,
   input wire logic flash_standby_o,
   input wire logic [NUM_BANKS-1:0] bank_busy_o,
   input wire cmd_status_t status_o,
   input wire logic irq_o,
   input wire logic [CFG_BITS-1:0] config_bits_o,
   input wire logic bod_en_o,
   input wire logic bod_rst_en_o,
   input wire logic security_o,
   input wire logic [2*LOCK_BITS-1:0] lock_bits_o,
   input wire logic remapped_o
);
   // --------------------------------
   // helpers
   // --------------------------------
   localparam int MAX_BUSY = 60;
   logic [31:0] hold_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // cycles the erase pin has stayed high
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !erase_pin_i) begin
         hold_q <= '0;
      end else if (hold_q != 32'hffff_ffff) begin
         hold_q <= hold_q + 32'h1;
      end
   end
   // plain core read of one 1 Mbyte area
   function automatic logic core_rd(bus_req_t r, logic [11:0] area);
      return r.valid && !r.write && !r.debug_src && !r.fast_prog_src && r.addr[31:20] == area;
   endfunction
   // zero read while map state holds still
   sequence zero_rd_s;
      core_rd(bus_req_i, 12'h000) ##1 $stable(remapped_o) && $stable(config_bits_o)
      ##1 $stable(remapped_o) && $stable(config_bits_o);
   endsequence
   // keyed program into a locked region of an idle bank
   sequence locked_prog_s;
      cmd_i.valid && cmd_i.key == CMD_KEY && cmd_i.code inside {CMD_PROG, CMD_PROG_ERASE}
      && lock_bits_o[{cmd_i.bank, cmd_i.page[9:6]}] && !bank_busy_o[cmd_i.bank];
   endsequence
   // keyed command into a bank well inside its busy time
   sequence busy_cmd_s;
      cmd_i.valid && cmd_i.key == CMD_KEY && cmd_i.code != CMD_NONE && bank_busy_o[cmd_i.bank]
      && !status_o.done && !$past(status_o.done) && !$past(status_o.done, 2);
   endsequence
   // --------------------------------
   // assertions
   // --------------------------------
   chk_rom_fixed:
      assert property (core_rd(bus_req_i, ROM_BASE[31:20]) |=> sel_o == SEL_ROM) else $error("rom decode wrong");
   chk_flash_fixed:
      assert property (core_rd(bus_req_i, FLASH_BASE[31:20]) |=> sel_o == SEL_FLASH) else $error("flash decode wrong");
   chk_sram_base:
      assert property (core_rd(bus_req_i, SRAM_BASE[31:20]) |=> sel_o == SEL_SRAM) else $error("sram decode wrong");
   chk_zero_alias:
      assert property (zero_rd_s |-> $past(sel_o) == (remapped_o ? SEL_SRAM :
         (config_bits_o[CFG_BOOT_FLASH] ? SEL_FLASH : SEL_ROM))) else $error("zero alias wrong");
   chk_secure_deny:
      assert property (bus_req_i.valid && (bus_req_i.debug_src || bus_req_i.fast_prog_src)
         && bus_req_i.addr[31:20] == FLASH_BASE[31:20] && security_o && $past(security_o)
         |=> sel_o == SEL_DENY) else $error("secure access not denied");
   chk_lock_abort:
      assert property (locked_prog_s |=> status_o.lock_err && irq_o && !status_o.done) else $error("locked program ran");
   chk_bad_key:
      assert property (cmd_i.valid && cmd_i.key != CMD_KEY && cmd_i.code != CMD_NONE
         |=> status_o.cmd_err && irq_o) else $error("bad key not flagged");
   chk_busy_refuse:
      assert property (busy_cmd_s |=> status_o.cmd_err && irq_o) else $error("busy bank took command");
   chk_busy_bound:
      assert property ($rose(bank_busy_o[0]) |-> ##[1:MAX_BUSY] !bank_busy_o[0]) else $error("bank stuck busy");
   chk_standby_idle:
      assert property (bank_busy_o[0] && $past(bank_busy_o[0]) |-> !flash_standby_o) else $error("standby while busy");
   chk_erase_clear:
      assert property (hold_q == ERASE_VALID_CYCLES + 8 |-> config_bits_o == '0 && lock_bits_o == '0)
         else $error("erase pin left bits set");
   chk_bod_follow:
      assert property (bod_en_o == config_bits_o[CFG_BOD_EN] && bod_rst_en_o == config_bits_o[CFG_BOD_RST])
         else $error("brownout enables differ from config");
endmodule
bind nvm_ctrl nvm_ctrl_chk #(.ERASE_VALID_CYCLES(ERASE_VALID_CYCLES)) chk (.ref_clk_i, .sys_rst_i, .erase_pin_i,
   .bus_req_i, .cmd_i, .sel_o, .flash_standby_o, .bank_busy_o, .status_o, .irq_o, .config_bits_o, .bod_en_o,
   .bod_rst_en_o, .security_o, .lock_bits_o, .remapped_o);

/* File: tb/tb.sv */
// testbench: directed and random checks of the flash nvm controller
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
   import nvm_ctrl_pkg::*;
   // --------------------------------
   // signals
   // --------------------------------
   localparam int PE = 20;
   localparam int PO = 10;
   localparam int FE = 40;
   localparam int EV = 30;
   logic ref_clk_i, sys_rst_i, erase_pin_i, remap_i, go, wr, dbg, fp;
   logic [31:0] addr, wdata_i, seed, tmp, wd, prefetch_data_o, lock_bits_o;
   bus_req_t bus_req_i;
   cmd_req_t cmd_i;
   logic [1:0] wait_states_i, bank_busy_o;
   mem_sel_t sel_o;
   logic refused_o, prefetch_hit_o, flash_standby_o, irq_o, bod_en_o, bod_rst_en_o, security_o, remapped_o, irq_acc;
   cmd_status_t status_o;
   logic [2:0] config_bits_o, st_acc;
   logic [5:0] wbuf_index_o;
   int err_count, total_checks, n0, n1, n2, i;
   nvm_ctrl #(.PROG_ERASE_CYCLES(PE), .PROG_ONLY_CYCLES(PO), .FULL_ERASE_CYCLES(FE), .ERASE_VALID_CYCLES(EV)) dut (
      .ref_clk_i, .sys_rst_i, .erase_pin_i, .remap_i, .bus_req_i, .wdata_i, .cmd_i, .wait_states_i, .sel_o,
      .refused_o, .prefetch_hit_o, .prefetch_data_o, .flash_standby_o, .bank_busy_o, .status_o, .irq_o,
      .config_bits_o, .bod_en_o, .bod_rst_en_o, .security_o, .lock_bits_o, .remapped_o, .wbuf_index_o);
   bus_master_model bm (.ref_clk_i, .go_i(go), .write_i(wr), .debug_i(dbg), .fast_prog_i(fp), .addr_i(addr),
      .req_o(bus_req_i));
   // 40 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // --------------------------------
   // helpers
   // --------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic mem_sel_t zero_exp(logic rm, logic boot);
      return rm ? SEL_SRAM : (boot ? SEL_FLASH : SEL_ROM);
   endfunction
   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one bus request through the partner, decode settled afterwards
   task automatic access(input logic [31:0] a, input logic d, input logic f, input logic w);
      @(negedge ref_clk_i);
      go = 1'b1; addr = a; dbg = d; fp = f; wr = w; wdata_i = rnd();
      @(negedge ref_clk_i);
      go = 1'b0;
      @(negedge ref_clk_i);
   endtask
   task automatic rd(input logic [31:0] a, input logic d, input mem_sel_t e);
      access(a, d, 1'b0, 1'b0);
      `CHK(sel_o, e)
   endtask
   // one command pulse; status pulses gathered over the answer window
   task automatic issue(input cmd_code_t c, input logic b, input logic [9:0] p, input logic [1:0] bs,
                        input logic [7:0] k);
      @(negedge ref_clk_i);
      cmd_i = '{valid: 1'b1, key: k, code: c, bank: b, page: p, bit_sel: bs};
      st_acc = '0;
      irq_acc = 1'b0;
      repeat (3) begin
         @(negedge ref_clk_i);
         cmd_i.valid = 1'b0;
         st_acc = st_acc | status_o;
         irq_acc = irq_acc | irq_o;
      end
   endtask
   // cycles from command to its done pulse
   task automatic timed(input cmd_code_t c, input logic b, output int n);
      issue(c, b, 10'h000, 2'h0, CMD_KEY);
      n = 3;
      while (status_o.done !== 1'b1 && n < 200) begin
         @(negedge ref_clk_i);
         n++;
      end
      repeat (4) @(negedge ref_clk_i);
   endtask
   // --------------------------------
   // main sequence
   // --------------------------------
   initial begin
      seed = 32'hb5f8; err_count = 0; total_checks = 0; sys_rst_i = 1'b1; erase_pin_i = 1'b0; remap_i = 1'b0;
      go = 1'b0; wr = 1'b0; dbg = 1'b0; fp = 1'b0; addr = '0; wdata_i = '0; cmd_i = '0; wait_states_i = 2'h1;
      repeat (10) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      @(negedge ref_clk_i);
      `CHK(flash_standby_o, 1'b1)
      `CHK({config_bits_o, security_o, lock_bits_o, remapped_o}, 37'h0)
      for (i = 0; i < 8; i++) begin
         tmp = rnd();
         wait_states_i = tmp[1:0];
         rd(FLASH_BASE | (rnd() & 32'h000f_fffc), 1'b0, SEL_FLASH);
         rd(SRAM_BASE | (rnd() & 32'h000f_fffc), 1'b0, SEL_SRAM);
         rd(ROM_BASE | (rnd() & 32'h000f_fffc), 1'b0, SEL_ROM);
         rd(ZERO_BASE | (rnd() & 32'h000f_fffc), 1'b0, zero_exp(1'b0, 1'b0));
      end
      timed(CMD_PROG_ERASE, 1'b0, n0);
      timed(CMD_PROG, 1'b1, n1);
      timed(CMD_FULL_ERASE, 1'b0, n2);
      `CHK(n0 - n1, PE - PO)
      `CHK(n2 - n1, FE - PO)
      issue(CMD_PROG_ERASE, 1'b0, 10'h000, 2'h0, CMD_KEY);
      `CHK(bank_busy_o, 2'b01)
      `CHK(flash_standby_o, 1'b0)
      issue(CMD_PROG, 1'b0, 10'h001, 2'h0, CMD_KEY);
      `CHK({st_acc, irq_acc}, 4'b0011)
      rd(FLASH_BASE | 32'h0004_0000, 1'b0, SEL_FLASH);
      issue(CMD_PROG, 1'b1, 10'h002, 2'h0, CMD_KEY);
      `CHK(bank_busy_o, 2'b11)
      repeat (60) @(negedge ref_clk_i);
      issue(CMD_PROG, 1'b0, 10'h000, 2'h0, ~CMD_KEY);
      `CHK({st_acc, irq_acc, bank_busy_o}, 6'b001100)
      for (i = 0; i < 3; i++) begin
         issue(cmd_set_config_bit, 1'b0, 10'h000, 2'(i), CMD_KEY);
      end
      `CHK({config_bits_o, bod_en_o, bod_rst_en_o}, 5'b11111)
      rd(ZERO_BASE | 32'h0000_0040, 1'b0, zero_exp(1'b0, 1'b1));
      issue(cmd_clear_config_bit, 1'b0, 10'h000, 2'h1, CMD_KEY);
      `CHK({config_bits_o, bod_rst_en_o}, 4'b1010)
      tmp = rnd();
      issue(CMD_SET_LOCK, tmp[10], tmp[9:0], 2'h0, CMD_KEY);
      `CHK(lock_bits_o, 32'h1 << {tmp[10], tmp[9:6]})
      issue(CMD_PROG, tmp[10], {tmp[9:6], ~tmp[5:0]}, 2'h0, CMD_KEY);
      `CHK({st_acc, irq_acc, bank_busy_o}, 6'b010100)
      issue(CMD_CLEAR_LOCK, tmp[10], tmp[9:0], 2'h0, CMD_KEY);
      `CHK(lock_bits_o, 32'h0)
      issue(CMD_SET_LOCK, tmp[10], tmp[9:0], 2'h0, CMD_KEY);
      access(FLASH_BASE | {12'h000, tmp[19:8], tmp[7:2], 2'b00}, 1'b0, 1'b0, 1'b1);
      `CHK(wbuf_index_o, tmp[7:2])
      // word before the written one, then the written one out of the prefetch
      wd = wdata_i;
      wait_states_i = 2'h2;
      rd(FLASH_BASE + 32'h0000_00fc + {tmp[7:2], 2'b00}, 1'b0, SEL_FLASH);
      `CHK(prefetch_hit_o, 1'b0)
      rd(FLASH_BASE + 32'h0000_0100 + {tmp[7:2], 2'b00}, 1'b0, SEL_FLASH);
      `CHK({prefetch_hit_o, prefetch_data_o}, {1'b1, wd})
      issue(CMD_SET_SECURITY, 1'b0, 10'h000, 2'h0, CMD_KEY);
      `CHK(security_o, 1'b1)
      rd(FLASH_BASE | 32'h0000_0100, 1'b1, SEL_DENY);
      `CHK(refused_o, 1'b1)
      access(FLASH_BASE, 1'b0, 1'b1, 1'b0);
      `CHK(sel_o, SEL_DENY)
      rd(FLASH_BASE, 1'b0, SEL_FLASH);
      @(negedge ref_clk_i);
      remap_i = 1'b1;
      @(negedge ref_clk_i);
      remap_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rd(ZERO_BASE | 32'h0000_0200, 1'b0, zero_exp(1'b1, 1'b1));
      `CHK(remapped_o, 1'b1)
      erase_pin_i = 1'b1;
      repeat (10) @(negedge ref_clk_i);
      erase_pin_i = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      `CHK(config_bits_o, 3'b101)
      erase_pin_i = 1'b1;
      repeat (EV + 10) @(negedge ref_clk_i);
      erase_pin_i = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      `CHK({config_bits_o, lock_bits_o, security_o}, 36'h1)
      issue(CMD_FULL_ERASE, 1'b0, 10'h000, 2'h0, CMD_KEY);
      repeat (50) @(negedge ref_clk_i);
      `CHK(security_o, 1'b0)
      rd(FLASH_BASE, 1'b1, SEL_FLASH);
      give_verdict();
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      err_count++;
      give_verdict();
   end
endmodule
